// ===== tesl_pkg.sv
/*
 * constants, register map and state type of the two-wire event and shortcut logic.
 * assumes a 32-bit Avalon-MM slave with byte addresses, one aligned word per register.
 */
package tesl_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // task triggers
    localparam logic [ADDR_W-1:0] OFS_START_RX = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_START_TX = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STOP     = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_SUSPEND  = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_RESUME   = 12'h020;

    // event flags
    localparam logic [ADDR_W-1:0] OFS_STOPPED_FLAG  = 12'h104;
    localparam logic [ADDR_W-1:0] OFS_RX_FLAG       = 12'h108;
    localparam logic [ADDR_W-1:0] OFS_TX_FLAG       = 12'h11c;
    localparam logic [ADDR_W-1:0] OFS_FAULT_FLAG    = 12'h124;
    localparam logic [ADDR_W-1:0] OFS_BOUNDARY_FLAG = 12'h138;
    localparam logic [ADDR_W-1:0] OFS_PAUSED_FLAG   = 12'h148;

    // shortcut register and its fields
    localparam logic [ADDR_W-1:0] OFS_SHORTCUTS    = 12'h200;
    localparam int                SHORT_PAUSE_BIT  = 0;
    localparam int                SHORT_HALT_BIT   = 1;
    localparam int                SHORT_W          = 2;
    localparam logic [SHORT_W-1:0] SHORT_RESET     = 2'h0;

    // data path and status
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 12'h600;
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 12'h604;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h608;
    localparam int                STAT_BUSY_BIT   = 0;
    localparam int                STAT_PAUSED_BIT = 1;
    localparam int                STAT_TXEMPTY_BIT = 2;

    localparam logic       FLAG_RESET    = 1'b0;
    localparam int         BYTE_W        = 8;
    localparam logic [3:0] LAST_BIT      = 4'h7;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam int         FIFO_DEPTH_DEF = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BOUND,
        ST_LOAD,
        ST_SHIFT,
        ST_ACK,
        ST_PAUSE,
        ST_STOP
    } tesl_state_t;

endpackage : tesl_pkg

// ===== tesl_event_logic.sv
/*
 * transmit byte FIFO and the event flag, shortcut and byte engine of a two-wire master.
 * assumes ref_clk at 200 MHz, srst synchronous, scl and sda arriving from pins
 * outside the clock domain and an external pull-up on sda.
 */
//
// What this block does
// - set byte-received flag when a whole byte is received and stored
// - set byte-sent flag when a transmit byte has been fully shifted out
// - set fault flag when a transmit byte is not acknowledged
// - raise byte-boundary flag before every byte sent or received
// - raise paused flag only in reads, after acknowledge, when suspend or shortcut bit 0 asked for a pause
// - shortcut bit 0 routes boundary to pause in transmit and to a pause after the next acknowledge in reads, bit 1 routes boundary to stop
// - suspend trigger pauses the transfer, resume trigger continues it
// - stop trigger written with 1 ends the transfer on the bus
// - set stopped flag once the stop condition has completed
`timescale 1ns/1ps

module tesl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IW-1:0]    wrIdx_q;
    logic [IW-1:0]    rdIdx_q;
    logic [CW-1:0]    count_q;

    wire push = inValid & inReady;
    wire pop  = outValid & outReady;

    assign inReady  = (count_q != FULL_CNT);
    assign outValid = (count_q != '0);
    assign outData  = mem_q[rdIdx_q];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wrIdx_q] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrIdx_q <= '0;
            rdIdx_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrIdx_q <= (wrIdx_q == LAST_IDX) ? '0 : wrIdx_q + 1'b1;
            end
            if (pop) begin
                rdIdx_q <= (rdIdx_q == LAST_IDX) ? '0 : rdIdx_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule : tesl_fifo

module tesl_event_logic #(
    parameter int FIFO_DEPTH = tesl_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    input  wire logic [tesl_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [tesl_pkg::DATA_W-1:0] avs_writedata,
    output logic      [tesl_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        sclIn,
    input  wire logic                        sdaIn,
    output logic                             sdaOut,
    output logic                             sdaOe
);
    import tesl_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction : hit

    // set wins over a software write in the same cycle
    function automatic logic nextFlag(input logic q, input logic set, input logic wr,
                                      input logic wd);
        return set | (wr ? wd : q);
    endfunction : nextFlag

    logic              waitReq_q;
    logic [DATA_W-1:0] readData_q;
    logic              sclS1_q, sclS2_q, sclS3_q;
    logic              sdaS1_q, sdaS2_q;
    tesl_state_t       state_q;
    logic              txMode_q;
    logic [3:0]        bitCnt_q;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] rxData_q;
    logic              suspReq_q;
    logic              stopReq_q;
    logic              nack_q;
    logic              stopArm_q;
    logic              sdaOe_q;
    logic [SHORT_W-1:0] short_q;
    logic              stoppedFlag_q, rxFlag_q, txFlag_q;
    logic              faultFlag_q, boundFlag_q, pausedFlag_q;
    logic              fifoInReady;
    logic [BYTE_W-1:0] fifoOutData;
    logic              fifoOutValid;

    // bus decode
    wire busReq    = avs_read | avs_write;
    wire hitTxData = hit(avs_address, OFS_TX_DATA);
    wire accept    = busReq & waitReq_q & ~(avs_write & hitTxData & ~fifoInReady);
    wire wrCommit  = avs_write & ~waitReq_q;
    wire wd0       = avs_writedata[0];

    wire wStartRx = wrCommit & hit(avs_address, OFS_START_RX) & wd0;
    wire wStartTx = wrCommit & hit(avs_address, OFS_START_TX) & wd0;
    wire wStop    = wrCommit & hit(avs_address, OFS_STOP) & wd0;
    wire wSusp    = wrCommit & hit(avs_address, OFS_SUSPEND) & wd0;
    wire wResume  = wrCommit & hit(avs_address, OFS_RESUME) & wd0;
    wire wShort   = wrCommit & hit(avs_address, OFS_SHORTCUTS);
    wire pushTx   = wrCommit & hitTxData;

    wire wrStoppedF = wrCommit & hit(avs_address, OFS_STOPPED_FLAG);
    wire wrRxF      = wrCommit & hit(avs_address, OFS_RX_FLAG);
    wire wrTxF      = wrCommit & hit(avs_address, OFS_TX_FLAG);
    wire wrFaultF   = wrCommit & hit(avs_address, OFS_FAULT_FLAG);
    wire wrBoundF   = wrCommit & hit(avs_address, OFS_BOUNDARY_FLAG);
    wire wrPausedF  = wrCommit & hit(avs_address, OFS_PAUSED_FLAG);

    wire [DATA_W-1:0] statusWord = {{(DATA_W-3){1'b0}}, ~fifoOutValid,
                                    state_q == ST_PAUSE, state_q != ST_IDLE};
    wire a = 1'b0;
    wire [DATA_W-1:0] readMux =
        hit(avs_address, OFS_STOPPED_FLAG)  ? DATA_W'(stoppedFlag_q) :
        hit(avs_address, OFS_RX_FLAG)       ? DATA_W'(rxFlag_q) :
        hit(avs_address, OFS_TX_FLAG)       ? DATA_W'(txFlag_q) :
        hit(avs_address, OFS_FAULT_FLAG)    ? DATA_W'(faultFlag_q) :
        hit(avs_address, OFS_BOUNDARY_FLAG) ? DATA_W'(boundFlag_q) :
        hit(avs_address, OFS_PAUSED_FLAG)   ? DATA_W'(pausedFlag_q) :
        hit(avs_address, OFS_SHORTCUTS)     ? DATA_W'(short_q) :
        hit(avs_address, OFS_RX_DATA)       ? DATA_W'(rxData_q) :
        hit(avs_address, OFS_STATUS)        ? statusWord : '0;

    // link edges from the synchronised clock
    wire sclRise = sclS2_q & ~sclS3_q;
    wire sclFall = ~sclS2_q & sclS3_q;
    wire sclHigh = sclS2_q;

    // engine events
    wire atBound  = (state_q == ST_BOUND) & ~sclHigh;
    wire ackEnd   = (state_q == ST_ACK) & sclFall;
    wire pauseNow = suspReq_q | short_q[SHORT_PAUSE_BIT] | wSusp;
    wire stopNow  = stopReq_q | short_q[SHORT_HALT_BIT] | wStop;
    wire evBound  = atBound;
    wire evTx     = (state_q == ST_SHIFT) & txMode_q & sclFall & (bitCnt_q == LAST_BIT);
    wire evRx     = ackEnd & ~txMode_q;
    wire evFault  = ackEnd & txMode_q & nack_q;
    wire evPause  = evRx & suspReq_q;
    wire evStopped = ((state_q == ST_STOP) & sclHigh & stopArm_q)
                   | ((state_q == ST_IDLE) & wStop);
    wire fifoPop  = (state_q == ST_LOAD) & fifoOutValid & ~wStop;

    tesl_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_txFifo (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .inData   (avs_writedata[BYTE_W-1:0]),
        .inValid  (pushTx),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoPop)
    );

    // one wait cycle per access, longer for a transmit-data write while the transmit FIFO is full
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            waitReq_q  <= 1'b1;
            readData_q <= '0;
        end else begin
            waitReq_q <= ~accept;
            if (accept & avs_read) begin
                readData_q <= readMux;
            end
        end
    end

    assign avs_waitrequest = waitReq_q;
    assign avs_readdata    = readData_q;
    assign sdaOe           = sdaOe_q;
    assign sdaOut          = a;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclS1_q <= 1'b1;
            sclS2_q <= 1'b1;
            sclS3_q <= 1'b1;
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
        end else begin
            sclS1_q <= sclIn;
            sclS2_q <= sclS1_q;
            sclS3_q <= sclS2_q;
            sdaS1_q <= sdaIn;
            sdaS2_q <= sdaS1_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            short_q       <= SHORT_RESET;
            stoppedFlag_q <= FLAG_RESET;
            rxFlag_q      <= FLAG_RESET;
            txFlag_q      <= FLAG_RESET;
            faultFlag_q   <= FLAG_RESET;
            boundFlag_q   <= FLAG_RESET;
            pausedFlag_q  <= FLAG_RESET;
        end else begin
            if (wShort) begin
                short_q <= avs_writedata[SHORT_W-1:0];
            end
            stoppedFlag_q <= nextFlag(stoppedFlag_q, evStopped, wrStoppedF, wd0);
            rxFlag_q      <= nextFlag(rxFlag_q, evRx, wrRxF, wd0);
            txFlag_q      <= nextFlag(txFlag_q, evTx, wrTxF, wd0);
            faultFlag_q   <= nextFlag(faultFlag_q, evFault, wrFaultF, wd0);
            boundFlag_q   <= nextFlag(boundFlag_q, evBound, wrBoundF, wd0);
            pausedFlag_q  <= nextFlag(pausedFlag_q, evPause, wrPausedF, wd0);
        end
    end

    // byte engine: bits change while scl is low, sampled on its rise
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q   <= ST_IDLE;
            txMode_q  <= 1'b0;
            bitCnt_q  <= '0;
            shift_q   <= '0;
            rxData_q  <= '0;
            suspReq_q <= 1'b0;
            stopReq_q <= 1'b0;
            nack_q    <= 1'b0;
            stopArm_q <= 1'b0;
            sdaOe_q   <= 1'b0;
        end else begin
            if (wSusp & (state_q != ST_IDLE)) begin
                suspReq_q <= 1'b1;
            end
            if (wStop & (state_q != ST_IDLE)) begin
                stopReq_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    suspReq_q <= 1'b0;
                    stopReq_q <= 1'b0;
                    if (wStartRx | wStartTx) begin
                        txMode_q <= wStartTx;
                        sdaOe_q  <= 1'b1;
                        state_q  <= ST_BOUND;
                    end
                end
                ST_BOUND: begin
                    if (atBound) begin
                        suspReq_q <= pauseNow;
                        bitCnt_q  <= '0;
                        if (stopNow) begin
                            stopArm_q <= 1'b0;
                            state_q   <= ST_STOP;
                        end else if (txMode_q & pauseNow) begin
                            state_q <= ST_PAUSE;
                        end else if (txMode_q) begin
                            state_q <= ST_LOAD;
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= ST_SHIFT;
                        end
                    end
                end
                ST_LOAD: begin
                    if (wStop) begin
                        stopArm_q <= 1'b0;
                        state_q   <= ST_STOP;
                    end else if (fifoOutValid) begin
                        shift_q <= fifoOutData;
                        sdaOe_q <= ~fifoOutData[BYTE_W-1];
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (txMode_q & sclFall) begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                        shift_q  <= {shift_q[BYTE_W-2:0], 1'b0};
                        sdaOe_q  <= (bitCnt_q == LAST_BIT) ? 1'b0 : ~shift_q[BYTE_W-2];
                        if (bitCnt_q == LAST_BIT) begin
                            state_q <= ST_ACK;
                        end
                    end
                    if (~txMode_q & sclRise) begin
                        shift_q  <= {shift_q[BYTE_W-2:0], sdaS2_q};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                    if (~txMode_q & sclFall & (bitCnt_q == BYTE_BITS)) begin
                        sdaOe_q <= 1'b1;
                        state_q <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (sclRise) begin
                        nack_q <= sdaS2_q;
                    end
                    if (sclFall) begin
                        sdaOe_q <= 1'b0;
                        if (~txMode_q) begin
                            rxData_q <= shift_q;
                        end
                        if (txMode_q & nack_q) begin
                            stopArm_q <= 1'b0;
                            state_q   <= ST_STOP;
                        end else if (~txMode_q & suspReq_q) begin
                            state_q <= ST_PAUSE;
                        end else if (stopReq_q | wStop) begin
                            stopArm_q <= 1'b0;
                            state_q   <= ST_STOP;
                        end else begin
                            state_q <= ST_BOUND;
                        end
                    end
                end
                ST_PAUSE: begin
                    if (wStop) begin
                        stopArm_q <= 1'b0;
                        state_q   <= ST_STOP;
                    end else if (wResume) begin
                        suspReq_q <= 1'b0;
                        state_q   <= ST_BOUND;
                    end
                end
                ST_STOP: begin
                    if (~sclHigh) begin
                        sdaOe_q   <= 1'b1;
                        stopArm_q <= 1'b1;
                    end else if (stopArm_q) begin
                        sdaOe_q   <= 1'b0;
                        stopArm_q <= 1'b0;
                        state_q   <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence byteTail;
        (state_q == ST_ACK) && sclFall;
    endsequence

    sequence boundaryTaken;
        (state_q == ST_BOUND) && !sclHigh;
    endsequence

    rx_flag_set_a: assert property (byteTail ##0 !txMode_q |=> rxFlag_q && rxData_q == $past(shift_q))
        else $error("byte received without flag");
    tx_flag_set_a: assert property ((state_q == ST_SHIFT && txMode_q && sclFall && bitCnt_q == 4'h7)
                                    |=> txFlag_q && state_q == ST_ACK)
        else $error("byte sent without flag");
    fault_flag_a: assert property (byteTail ##0 (txMode_q && nack_q) |=> faultFlag_q ##0 state_q == ST_STOP)
        else $error("missing acknowledge not flagged");
    boundary_flag_a: assert property ($rose(state_q == ST_SHIFT) && txMode_q |-> boundFlag_q || $past(wrBoundF, 2)
                                      || $past(wrBoundF))
        else $error("byte started without boundary event");
    paused_read_a: assert property ($rose(pausedFlag_q) && !$past(wrPausedF)
                                    |-> $past(!txMode_q && suspReq_q)
                                    && state_q == ST_PAUSE)
        else $error("paused flag outside a suspended read");
    halt_route_a: assert property (boundaryTaken ##0 short_q[1] |=> state_q == ST_STOP)
        else $error("halt shortcut not taken");
    pause_route_a: assert property (boundaryTaken ##0 (short_q == 2'h1 && txMode_q && !stopReq_q && !wStop)
                                    |=> state_q == ST_PAUSE)
        else $error("pause shortcut not taken in transmit");
    resume_go_a: assert property (state_q == ST_PAUSE && wResume && !wStop |=> state_q == ST_BOUND)
        else $error("resume did not continue");
    stop_done_a: assert property (state_q == ST_IDLE && wStop |=> stoppedFlag_q)
        else $error("stop in idle gave no stopped event");
    stopped_flag_a: assert property ($fell(state_q == ST_STOP) |-> stoppedFlag_q && !sdaOe_q)
        else $error("stop completed without flag");
    flag_hold_a: assert property (rxFlag_q && !wrRxF |=> rxFlag_q)
        else $error("flag dropped without a write");
    bus_answer_a: assert property (accept |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not a single cycle");
endmodule : tesl_event_logic

// ===== tesl_slave_model.sv
/*
 * behavioural two-wire slave: paces the link clock and answers bytes.
 * assumes sda has a pull-up; scl stands high outside frames.
 */
`timescale 1ns/1ps

module tesl_slave_model (
    input  wire logic       run,
    input  wire logic       rdMode,
    input  wire logic       nack,
    input  wire logic [7:0] txByte,
    input  wire logic       sdaWire,
    output logic            sclOut,
    output logic            sdaPull,
    output logic [7:0]      gotByte
);
    int f;
    int p;
    logic [7:0] sh;
    // nine scl periods per byte: eight data slots, one acknowledge slot
    always begin
        sclOut  = 1'b1;
        sdaPull = 1'b0;
        f       = 0;
        wait (run);
        #40;
        while (run) begin
            #32 sclOut = 1'b0;
            p = f % 9;
            f++;
            #8 sdaPull = rdMode ? (p < 8 && !txByte[7-p]) : (p == 8 && !nack);
            // only a complete byte is published, so a cut frame leaves it intact
            if (!rdMode && p == 8) gotByte = sh;
            #24 sclOut = 1'b1;
            if (!rdMode && p < 8) sh[7-p] = sdaWire;
        end
    end
endmodule : tesl_slave_model

// ===== tesl_event_logic_test.sv
/*
 * self-checking bench of the event flag and shortcut logic.
 * assumes the slave model on the link side and a pull-up on sda.
 */
`timescale 1ns/1ps

module tesl_event_logic_test;
    import tesl_pkg::*;
    logic              ref_clk, srst, avsRead, avsWrite, avsWaitrequest;
    logic [ADDR_W-1:0] avsAddress;
    logic [DATA_W-1:0] avsWritedata, avsReaddata, q, rnd;
    logic              sclIn, sdaOut, sdaOe, sdaPull, sdaWire, run, rdMode, nack;
    logic [7:0]        txByte, gotByte;
    int                nMismatch, totalChecks, c;
    localparam logic [ADDR_W-1:0] FLAGS [6] = '{OFS_STOPPED_FLAG, OFS_RX_FLAG, OFS_TX_FLAG,
        OFS_FAULT_FLAG, OFS_BOUNDARY_FLAG, OFS_PAUSED_FLAG};
    assign sdaWire = !((sdaOe && !sdaOut) || sdaPull);

    tesl_event_logic DUT (.ref_clk(ref_clk), .srst(srst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .sclIn(sclIn),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe));
    tesl_slave_model slave (.run(run), .rdMode(rdMode), .nack(nack), .txByte(txByte),
        .sdaWire(sdaWire), .sclOut(sclIn), .sdaPull(sdaPull), .gotByte(gotByte));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic tallyAndFinish();
        if (nMismatch == 0 && totalChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tallyAndFinish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= !wr;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (avsWaitrequest === 1'b0) break;
        end
        q = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
        if (n == 200) begin
            nMismatch++;
            tallyAndFinish();
        end
    endtask : bus

    task automatic waitFlag(input logic [ADDR_W-1:0] a);
        int n;
        for (n = 0; n < 600; n++) begin
            bus(1'b0, a, 32'h0);
            if (q === 32'h1) break;
        end
        if (n == 600) begin
            nMismatch++;
            tallyAndFinish();
        end
    endtask : waitFlag

    task automatic clearAll();
        foreach (FLAGS[i]) bus(1'b1, FLAGS[i], 32'h0);
    endtask : clearAll

    initial begin
        {srst, avsRead, avsWrite, run, rdMode, nack} = 6'h20;
        avsAddress   = '0;
        avsWritedata = '0;
        txByte       = 8'h00;
        rnd          = 32'hf496;
        nMismatch    = 0;
        totalChecks  = 0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (FLAGS[i]) begin
            bus(1'b0, FLAGS[i], 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b0, OFS_SHORTCUTS, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 12'h3fc, 32'h0);
        chk(q, 32'h0);
        rnd = lfsr(rnd);
        bus(1'b1, OFS_SHORTCUTS, rnd);
        bus(1'b0, OFS_SHORTCUTS, 32'h0);
        chk(q, {30'h0, rnd[1:0]});
        bus(1'b1, OFS_FAULT_FLAG, 32'h1);
        bus(1'b0, OFS_FAULT_FLAG, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, OFS_FAULT_FLAG, 32'h0);
        bus(1'b0, OFS_FAULT_FLAG, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_STOP, 32'h1);
        bus(1'b0, OFS_STOPPED_FLAG, 32'h0);
        chk(q, 32'h1);
        // transmit: acknowledged, refused, cut by the halt route, held by the pause route
        for (c = 0; c < 4; c++) begin
            clearAll();
            bus(1'b1, OFS_SHORTCUTS, (c == 2) ? 32'h2 : (c == 3) ? 32'h1 : 32'h0);
            rnd = lfsr(rnd);
            bus(1'b1, OFS_TX_DATA, rnd);
            nack <= (c == 1);
            rdMode <= 1'b0;
            run <= 1'b1;
            bus(1'b1, OFS_START_TX, 32'h1);
            waitFlag(c == 0 ? OFS_TX_FLAG : c == 1 ? OFS_FAULT_FLAG :
                     c == 2 ? OFS_STOPPED_FLAG : OFS_BOUNDARY_FLAG);
            if (c == 3) begin
                bus(1'b0, OFS_STATUS, 32'h0);
                chk(q[STAT_PAUSED_BIT], 1'b1);
            end
            if (c == 0 || c == 3) bus(1'b1, OFS_STOP, 32'h1);
            waitFlag(OFS_STOPPED_FLAG);
            run <= 1'b0;
            if (c < 2) chk(gotByte, rnd[7:0]);
            bus(1'b0, OFS_TX_FLAG, 32'h0);
            chk(q, {31'h0, c < 2});
            bus(1'b0, OFS_FAULT_FLAG, 32'h0);
            chk(q, {31'h0, c == 1});
            bus(1'b0, OFS_BOUNDARY_FLAG, 32'h0);
            chk(q, 32'h1);
            bus(1'b0, OFS_PAUSED_FLAG, 32'h0);
            chk(q, 32'h0);
            repeat (40) @(posedge ref_clk);
        end
        // receive with a pause after the acknowledge, then resume and stop
        clearAll();
        bus(1'b1, OFS_SHORTCUTS, 32'h0);
        rnd = lfsr(rnd);
        txByte <= rnd[7:0];
        rdMode <= 1'b1;
        run <= 1'b1;
        bus(1'b1, OFS_START_RX, 32'h1);
        bus(1'b1, OFS_SUSPEND, 32'h1);
        waitFlag(OFS_PAUSED_FLAG);
        bus(1'b0, OFS_RX_FLAG, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, OFS_RX_DATA, 32'h0);
        chk(q, {24'h0, rnd[7:0]});
        bus(1'b0, OFS_BOUNDARY_FLAG, 32'h0);
        chk(q, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q[STAT_PAUSED_BIT], 1'b1);
        rdMode <= 1'b0;
        nack <= 1'b1;
        bus(1'b1, OFS_RESUME, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q[STAT_PAUSED_BIT], 1'b0);
        bus(1'b1, OFS_STOP, 32'h1);
        waitFlag(OFS_STOPPED_FLAG);
        run <= 1'b0;
        tallyAndFinish();
    end
endmodule : tesl_event_logic_test
